// *** msadc_pkg.sv ***
// Shared constants, types and helpers for the monitor ADC serial control block
package msadc_pkg;

    // Result and configuration word geometry
    localparam int RES_W = 10;
    localparam int CFG_W = 3;
    localparam int CFG_SEL_HI = 2;
    localparam int CFG_SEL_LO = 1;
    localparam int CFG_ORDER = 0;
    localparam logic [1:0] CFG_LAST_CNT = 2'h2;

    // Synchroniser lanes
    localparam int SYNC_W = 3;
    localparam int LANE_CS = 0;
    localparam int LANE_SCLK = 1;
    localparam int LANE_DIN = 2;

    // Output sequence indexes: null, MSB-first run, LSB-first run, zero fill
    localparam logic [4:0] SEQ_NULL = 5'h00;
    localparam logic [4:0] SEQ_MSB_FIRST = 5'h01;
    localparam logic [4:0] SEQ_LSB_FIRST = 5'h0B;
    localparam logic [4:0] SEQ_FILL = 5'h15;

    // Measurement modes
    typedef enum logic [1:0] {
        MODE_TEMP = 2'h0,
        MODE_SUPPLY = 2'h1,
        MODE_DIFF_FULL = 2'h2,
        MODE_DIFF_HALF = 2'h3
    } msadc_mode_t;

    // Transfer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_HUNT = 3'h1,
        ST_CFG = 3'h2,
        ST_TURN = 3'h3,
        ST_SEND = 3'h4
    } msadc_state_t;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
    } msadc_sync_t;

    typedef struct packed {
        logic [4:0] idx;
        logic [RES_W-1:0] word;
    } msadc_shift_t;

    typedef struct packed {
        msadc_state_t state;
        logic [1:0] cfg_cnt;
        logic [CFG_W-1:0] cfg;
        logic dout;
        logic dout_oe;
        logic conv_start;
        msadc_mode_t mode;
        logic order;
        logic active;
        logic frame_done;
        logic aborted;
        logic temp_discard;
        logic mode_seen;
    } msadc_ctrl_t;

    // Values after reset; chip select lanes start deselected
    localparam msadc_sync_t SYNC_RST = '{s1: 3'h1, s2: 3'h1, s3: 3'h1};
    localparam msadc_shift_t SHIFT_RST = '{idx: 5'h00, word: 10'h000};
    localparam msadc_ctrl_t CTRL_RST = msadc_ctrl_t'('0);

    // Edge detectors on synchronised levels
    function automatic logic msadc_rise(input logic prev, input logic cur);
        return ~prev & cur;
    endfunction

    function automatic logic msadc_fall(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction

endpackage

// *** msadc_pin_if.sv ***
// Synchronised pin levels and edge pulses passed to the controller
`timescale 1ns/1ps
interface msadc_pin_if;
    logic cs_n;
    logic din;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    modport src(output cs_n, din, cs_fall, cs_rise, sclk_rise, sclk_fall);
    modport dst(input cs_n, din, cs_fall, cs_rise, sclk_rise, sclk_fall);
endinterface

// *** msadc_pin_sync.sv ***
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module msadc_pin_sync import msadc_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Raw pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    // Synchronised view
    msadc_pin_if.src pins
);

    msadc_sync_t q;
    msadc_sync_t d;

    // Stage shift; only s2 and s3 feed logic
    always_comb begin
        d = q;
        d.s1 = {i_din, i_sclk, i_cs_n};
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= SYNC_RST;
        end else begin
            q <= d;
        end
    end

    // Levels and edges, all aligned to stage two
    assign pins.cs_n = q.s2[LANE_CS];
    assign pins.din = q.s2[LANE_DIN];
    assign pins.cs_fall = msadc_fall(q.s3[LANE_CS], q.s2[LANE_CS]);
    assign pins.cs_rise = msadc_rise(q.s3[LANE_CS], q.s2[LANE_CS]);
    assign pins.sclk_rise = msadc_rise(q.s3[LANE_SCLK], q.s2[LANE_SCLK]);
    assign pins.sclk_fall = msadc_fall(q.s3[LANE_SCLK], q.s2[LANE_SCLK]);

endmodule

// *** msadc_shifter.sv ***
// Result serialiser: null bit, MSB-first run, optional LSB-first run, zero fill
`timescale 1ns/1ps
module msadc_shifter import msadc_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Control
    input wire logic i_load,
    input wire logic i_step,
    input wire logic i_lsb_tail,
    // Result in
    input wire logic [RES_W-1:0] i_data,
    // Serial bit and status
    output logic o_bit,
    output logic o_done
);

    msadc_shift_t q;
    msadc_shift_t d;

    // Sequence advance and bit selection
    always_comb begin
        logic [4:0] pos;
        pos = 5'h00;
        d = q;
        o_bit = 1'b0;
        if (q.idx >= SEQ_MSB_FIRST && q.idx < SEQ_LSB_FIRST) begin
            pos = 5'(RES_W) - q.idx;
            o_bit = q.word[pos[3:0]];
        end else if (q.idx >= SEQ_LSB_FIRST && q.idx < SEQ_FILL && i_lsb_tail) begin
            pos = q.idx - SEQ_LSB_FIRST;
            o_bit = q.word[pos[3:0]];
        end
        o_done = (q.idx == SEQ_FILL) || (q.idx >= SEQ_LSB_FIRST && !i_lsb_tail);
        if (i_load) begin
            d.idx = SEQ_NULL;
        end else if (i_step) begin
            if (q.idx == SEQ_NULL) begin
                d.word = i_data;
            end
            if (q.idx != SEQ_FILL) begin
                d.idx = q.idx + 5'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= SHIFT_RST;
        end else begin
            q <= d;
        end
    end

    // Zero fill once the MSB-only run is over
    chk_fill_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_lsb_tail && q.idx >= SEQ_LSB_FIRST) |-> !o_bit)
        else $error("fill bit not zero in MSB-only order");

    // One step moves exactly one bit
    chk_one_step: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_step && !i_load && q.idx != SEQ_FILL) |=> q.idx == $past(q.idx) + 5'h01)
        else $error("serialiser index did not advance by one");

endmodule

// *** msadc_serial_ctrl.sv ***
// Serial control and transfer logic of the monitor ADC
`timescale 1ns/1ps
module msadc_serial_ctrl import msadc_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Serial pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    output logic o_dout,
    output logic o_dout_oe,
    // Converter side
    input wire logic [RES_W-1:0] i_conv_result,
    output logic o_conv_start,
    output logic [1:0] o_mode,
    output logic o_bit_order_select,
    // Status
    output logic o_active,
    output logic o_frame_done,
    output logic o_aborted,
    output logic o_temp_discard
);

    msadc_pin_if pins();

    msadc_ctrl_t q;
    msadc_ctrl_t d;
    logic shift_load;
    logic shift_step;
    logic shift_bit;
    logic shift_done;

    // Pin synchroniser
    msadc_pin_sync u_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_cs_n(i_cs_n),
        .i_sclk(i_sclk),
        .i_din(i_din),
        .pins(pins)
    );

    // Result serialiser
    msadc_shifter u_shift (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_load(shift_load),
        .i_step(shift_step),
        .i_lsb_tail(~q.order),
        .i_data(i_conv_result),
        .o_bit(shift_bit),
        .o_done(shift_done)
    );

    // Transfer sequencing
    always_comb begin
        d = q;
        d.conv_start = 1'b0;
        d.frame_done = 1'b0;
        d.aborted = 1'b0;
        shift_load = 1'b0;
        shift_step = 1'b0;
        if (pins.cs_n) begin
            // Deselected: release the line and report how the frame ended
            d.state = ST_IDLE;
            d.dout_oe = 1'b0;
            d.dout = 1'b0;
            d.active = 1'b0;
            if (q.state == ST_SEND && shift_done) begin
                d.frame_done = 1'b1;
            end else if (q.state != ST_IDLE) begin
                d.aborted = 1'b1;
            end
        end else begin
            case (q.state)
                ST_IDLE: begin
                    if (pins.cs_fall) begin
                        d.state = ST_HUNT;
                        d.active = 1'b1;
                        d.dout_oe = 1'b0; // Line stays released while receiving
                        d.cfg_cnt = 2'h0;
                        d.cfg = '0;
                        shift_load = 1'b1;
                    end
                end
                ST_HUNT: begin
                    // Leading zeros are skipped
                    if (pins.sclk_rise && pins.din) begin
                        d.state = ST_CFG;
                        d.cfg_cnt = 2'h0;
                    end
                end
                ST_CFG: begin
                    if (pins.sclk_rise) begin
                        d.cfg = {q.cfg[CFG_W-2:0], pins.din};
                        d.cfg_cnt = q.cfg_cnt + 2'h1;
                        if (q.cfg_cnt == CFG_LAST_CNT) begin
                            // Word complete: latch mode and order, start conversion
                            d.state = ST_TURN;
                            d.mode = msadc_mode_t'(q.cfg[CFG_SEL_HI-1:CFG_SEL_LO-1]);
                            d.order = pins.din;
                            d.conv_start = 1'b1;
                            d.temp_discard = (q.cfg[CFG_SEL_HI-1:CFG_SEL_LO-1] == MODE_TEMP)
                                && (!q.mode_seen || q.mode != MODE_TEMP);
                            d.mode_seen = 1'b1;
                        end
                    end
                end
                ST_TURN: begin
                    // Input no longer shifted; output enabled with the null bit
                    if (pins.sclk_fall) begin
                        d.state = ST_SEND;
                        d.dout_oe = 1'b1;
                        d.dout = shift_bit;
                        shift_step = 1'b1;
                    end
                end
                ST_SEND: begin
                    // Data line changes only on falling edges; input ignored
                    if (pins.sclk_fall) begin
                        d.dout = shift_bit;
                        shift_step = 1'b1;
                    end
                end
                default: begin
                    d.state = ST_IDLE;
                    d.dout_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // Registered outputs
    assign o_dout = q.dout;
    assign o_dout_oe = q.dout_oe;
    assign o_conv_start = q.conv_start;
    assign o_mode = q.mode;
    assign o_bit_order_select = q.order;
    assign o_active = q.active;
    assign o_frame_done = q.frame_done;
    assign o_aborted = q.aborted;
    assign o_temp_discard = q.temp_discard;

    // Deselect releases the line one cycle later
    chk_idle_hiz: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        pins.cs_n |=> (!o_dout_oe && !o_active))
        else $error("output driven while deselected");

    // Receiving phases never drive
    chk_rx_no_drive: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (q.state == ST_HUNT || q.state == ST_CFG || q.state == ST_TURN) |-> !o_dout_oe)
        else $error("output driven while receiving");

    // Select fall starts a search
    chk_start_on_fall: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (q.state == ST_IDLE && pins.cs_fall) |=> (q.state == ST_HUNT && o_active))
        else $error("chip select fall did not start a transfer");

    // Only a sampled one leaves the search
    chk_start_bit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (q.state == ST_HUNT && !pins.cs_n && pins.sclk_rise)
        |=> ((q.state == ST_CFG) == $past(pins.din)))
        else $error("start bit detection wrong");

    // Conversion starts three rises after the start bit
    chk_cfg_three: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(o_conv_start) |-> ($past(q.state) == ST_CFG && $past(q.cfg_cnt) == CFG_LAST_CNT
            && q.state == ST_TURN))
        else $error("conversion start not after third config bit");

    // Mode and order stay frozen once the word is in
    chk_cfg_frozen: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (q.state == ST_SEND && !pins.cs_n) |=> ($stable(o_mode) && $stable(o_bit_order_select)))
        else $error("configuration changed after word complete");

    // First falling edge after the word enables the line with a null bit
    chk_null_bit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (q.state == ST_TURN && !pins.cs_n && pins.sclk_fall) |=> (o_dout_oe && !o_dout))
        else $error("null bit missing at output enable");

    // Enable rises only on a falling shift edge
    chk_oe_on_fall: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(o_dout_oe) |-> ($past(pins.sclk_fall) && $past(q.state) == ST_TURN))
        else $error("output enabled away from a falling edge");

    // Driven data changes only after a falling edge
    chk_dout_on_fall: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_dout_oe && $past(o_dout_oe) && $changed(o_dout)) |-> $past(pins.sclk_fall))
        else $error("data changed away from a falling edge");

    // Raising select ends the transfer within a cycle
    chk_cs_rise_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        pins.cs_rise |=> (q.state == ST_IDLE) [*2])
        else $error("chip select rise did not return to idle");

    // Mode field follows the two select bits
    chk_mode_map: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(o_conv_start) |-> (o_mode == $past(q.cfg[1:0])
            && o_bit_order_select == $past(pins.din)))
        else $error("mode or order not taken from config word");

    // Conversion start lasts one cycle
    chk_conv_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_conv_start |=> !o_conv_start)
        else $error("conversion start longer than one cycle");

    // Normal end pulse lasts one cycle
    chk_done_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_frame_done |=> !o_frame_done)
        else $error("frame done longer than one cycle");

    // Abort pulse lasts one cycle
    chk_abort_pulse: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_aborted |=> !o_aborted)
        else $error("abort longer than one cycle");

    // Either end report finds the interface idle
    chk_end_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_frame_done || o_aborted) |-> (q.state == ST_IDLE && !o_active && !o_dout_oe))
        else $error("frame end reported while interface busy");

    // Busy flag only follows a low select
    chk_active_sel: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_active |-> !$past(pins.cs_n))
        else $error("active while chip select high");

    // Idle holds until a select fall
    chk_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (q.state == ST_IDLE && !pins.cs_fall) |=> q.state == ST_IDLE)
        else $error("left idle without a chip select fall");

    // New frame clears the configuration shift
    chk_hunt_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (q.state == ST_IDLE && pins.cs_fall) |=> (q.cfg == '0 && q.cfg_cnt == 2'h0))
        else $error("configuration not cleared at frame start");

    // Result goes out only after the full word
    chk_word_first: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(o_dout_oe) |-> q.cfg_cnt == CFG_LAST_CNT + 2'h1)
        else $error("output enabled before the word was complete");

    // Released line carries a low level
    chk_released_low: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !o_dout_oe |-> !o_dout)
        else $error("data high while line released");

    // Driving phase keeps the line enabled
    chk_send_drives: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (q.state == ST_SEND) |-> o_dout_oe)
        else $error("line not driven while sending");

    // Enable holds while select stays low
    chk_oe_holds: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_dout_oe && !pins.cs_n) |=> o_dout_oe)
        else $error("output enable dropped inside a frame");

    // Configuration frozen after the word
    chk_cfg_ignored: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        ((q.state == ST_TURN || q.state == ST_SEND) && !pins.cs_n) |=> $stable(q.cfg))
        else $error("input shifted after word complete");

    // Serialiser only steps on a falling edge
    chk_step_on_fall: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        shift_step |-> (pins.sclk_fall && !pins.cs_n))
        else $error("serialiser stepped away from a falling edge");

    // Discard flag only marks temperature results
    chk_discard_mode: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_temp_discard |-> (o_mode == MODE_TEMP))
        else $error("discard flag set outside temperature mode");

endmodule

// *** msadc_host_model.sv ***
// Host model: drives chip select, shift clock and the shared data line
`timescale 1ns/1ps
module msadc_host_model (
    // Clock and resolved line
    input wire logic i_clk,
    input wire logic i_line,
    input wire logic i_dev_oe,
    // Host pins
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_data,
    output logic o_data_oe
);
    localparam int HALF = 10;
    int t;
    // Idle levels
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_data = 1'b0;
        o_data_oe = 1'b0;
    end
    // Wait clock edges, drive just after
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #5;
        t += n;
    endtask
    // One frame of lead zeros, word, 25 read bits; stops early at abort_at
    task automatic transfer(input int lead, input logic [3:0] word, input int abort_at,
                            output logic [24:0] rx, output logic oe_bad);
        rx = '0;
        oe_bad = 1'b0;
        t = 0;
        o_cs_n = 1'b0; // Frame opens on select fall
        tick(word[2:1] == 2'h0 ? 800 : 100); // Wake delay
        for (int i = 0; i < lead + 29; i++) begin
            if (i == abort_at) break;
            o_sclk = 1'b0; // Change on fall, sample on rise
            o_data = (i >= lead && i < lead + 4) ? word[lead+3-i] : 1'b0;
            o_data_oe = i < lead + 4; // Word first, then line released
            tick(HALF);
            oe_bad |= (i < lead + 4) && i_dev_oe;
            if (i >= lead + 4) rx = {rx[23:0], i_line};
            o_sclk = 1'b1;
            tick(HALF);
        end
        o_sclk = 1'b0;
        o_data_oe = 1'b0;
        // Minimum select low time
        while (abort_at < 0 && t < (word[2:1] == 2'h0 ? 1420 : 720)) tick(1);
        o_cs_n = 1'b1;
        tick(20); // Select high gap
    endtask
    // Clock ones in while deselected
    task automatic noise();
        o_data = 1'b1;
        o_data_oe = 1'b1;
        repeat (6) begin
            o_sclk = ~o_sclk;
            tick(HALF);
        end
        o_data_oe = 1'b0;
    endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the monitor ADC serial control block
`timescale 1ns/1ps
module tb;
    import msadc_pkg::*;
    typedef struct {
        int lead;
        logic [1:0] sel;
        logic ord;
        logic [RES_W-1:0] res;
        logic disc;
    } msadc_row_t;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [RES_W-1:0] conv_result = '0;
    logic cs_n, sclk, host_d, host_oe, dout, dout_oe, line, oe_bad;
    logic conv_start, order, active, frame_done, aborted, temp_discard;
    logic line_q = 1'b0;
    logic [1:0] mode;
    logic [24:0] rx;
    int num_errors = 0;
    int n_checks = 0;
    int n_start, n_done, n_abort;
    // Rows: lead zeros, select, order, result, expected discard flag
    msadc_row_t rows[8] = '{'{0, 2'h0, 1'b1, 10'h3FF, 1'b1}, '{2, 2'h0, 1'b0, 10'h26C, 1'b0},
        '{1, 2'h1, 1'b0, 10'h001, 1'b0}, '{0, 2'h0, 1'b1, 10'h200, 1'b1},
        '{3, 2'h2, 1'b1, 10'h155, 1'b0}, '{0, 2'h3, 1'b0, 10'h2AA, 1'b0},
        '{0, 2'h2, 1'b0, 10'h000, 1'b0}, '{5, 2'h0, 1'b0, 10'h3FE, 1'b1}};
    // Clock
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    // Shared wire; floating line toggles every cycle
    assign line = dout_oe ? dout : (host_oe ? host_d : ~line_q);
    always @(posedge i_clk) line_q <= (line === 1'b1);
    // Pulse counters
    always @(posedge i_clk) begin
        if (conv_start === 1'b1) n_start++;
        if (frame_done === 1'b1) n_done++;
        if (aborted === 1'b1) n_abort++;
    end
    msadc_serial_ctrl DUT (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(line),
        .o_dout(dout), .o_dout_oe(dout_oe), .i_conv_result(conv_result),
        .o_conv_start(conv_start), .o_mode(mode), .o_bit_order_select(order),
        .o_active(active), .o_frame_done(frame_done), .o_aborted(aborted),
        .o_temp_discard(temp_discard)
    );
    msadc_host_model host (
        .i_clk(i_clk), .i_line(line), .i_dev_oe(dout_oe), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_data(host_d), .o_data_oe(host_oe)
    );
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic clr();
        n_start = 0;
        n_done = 0;
        n_abort = 0;
    endtask
    // Bounded wait for the block to go idle
    task automatic settle();
        int k;
        for (k = 0; k < 30 && active !== 1'b0; k++) begin
            @(posedge i_clk);
            #5;
        end
        if (k == 30) begin
            num_errors++;
            end_of_test();
        end
    endtask
    // Null bit, MSB run, then LSB run or zeros
    function automatic logic [24:0] stream(input logic [9:0] r, input logic ord);
        logic [9:0] rev;
        for (int b = 0; b < 10; b++) rev[b] = r[9-b];
        return {1'b0, r, ord ? 10'h000 : rev, 4'h0};
    endfunction
    // Watchdog
    initial begin
        repeat (100000) @(posedge i_clk);
        num_errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge i_clk);
        #5;
        i_arst_n = 1'b1;
        check("oe_reset", dout_oe, 1'b0);
        check("active_reset", active, 1'b0);
        repeat (4) @(posedge i_clk);
        #5;
        foreach (rows[r]) begin
            conv_result = rows[r].res;
            clr();
            host.transfer(rows[r].lead, {1'b1, rows[r].sel, rows[r].ord}, -1, rx, oe_bad);
            settle();
            check("stream", rx, stream(rows[r].res, rows[r].ord));
            check("oe_rx", oe_bad, 1'b0);
            check("mode", mode, rows[r].sel);
            check("order", order, rows[r].ord);
            check("discard", temp_discard, rows[r].disc);
            check("starts", n_start, 1);
            check("done", n_done, 1);
            check("aborts", n_abort, 0);
            check("oe_idle", dout_oe, 1'b0);
        end
        // Deselected clocking is ignored
        clr();
        host.noise();
        repeat (8) @(posedge i_clk);
        #5;
        check("noise_starts", n_start, 0);
        check("noise_active", active, 1'b0);
        // Abort while searching for the start bit
        clr();
        host.transfer(3, 4'hB, 2, rx, oe_bad);
        settle();
        check("hunt_abort", n_abort, 1);
        check("hunt_starts", n_start, 0);
        // Abort after the null bit and two result bits
        clr();
        conv_result = 10'h2C3;
        host.transfer(0, 4'h9, 7, rx, oe_bad);
        settle();
        check("mid_bits", rx[2:0], 3'h2);
        check("mid_abort", n_abort, 1);
        check("mid_done", n_done, 0);
        check("mid_oe", dout_oe, 1'b0);
        // Reset mid-run clears order and the mode history
        i_arst_n = 1'b0;
        #1;
        check("rst_order", order, 1'b0);
        check("rst_oe", dout_oe, 1'b0);
        repeat (2) @(posedge i_clk);
        #5;
        i_arst_n = 1'b1;
        repeat (4) @(posedge i_clk);
        #5;
        clr();
        conv_result = 10'h19B;
        host.transfer(1, 4'h8, -1, rx, oe_bad);
        settle();
        check("rst_stream", rx, stream(10'h19B, 1'b0));
        check("rst_discard", temp_discard, 1'b1);
        check("rst_done", n_done, 1);
        end_of_test();
    end
endmodule
